// ===== src/pcsia_top.sv
`timescale 1ns/1ps
module pcsia_top (
	// Clock, reset and enable.
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	// Core sequencing commands.
	input  wire logic                          core_inc_i,
	input  wire logic                          core_goto_i,
	input  wire logic                          core_call_i,
	input  wire logic                          core_ret_i,
	input  wire logic                          core_irq_i,
	input  wire logic [pcsia_pkg::LIT_W-1:0]   core_lit_i,
	// Program counter view.
	output logic      [pcsia_pkg::PC_W-1:0]    pc_o,
	output logic      [pcsia_pkg::FETCH_W-1:0] fetch_addr_o,
	// Wishbone slave.
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [pcsia_pkg::WB_AW-1:0]   wb_adr_i,
	input  wire logic [pcsia_pkg::SEL_W-1:0]   wb_sel_i,
	input  wire logic [pcsia_pkg::WB_DW-1:0]   wb_dat_i,
	output logic      [pcsia_pkg::WB_DW-1:0]   wb_dat_o,
	output logic                               wb_ack_o,
	// Register file port for indirect access.
	output logic                               file_stb_o,
	output logic                               file_we_o,
	output logic      [pcsia_pkg::FILE_AW-1:0] file_addr_o,
	output logic      [pcsia_pkg::DW-1:0]      file_wdata_o,
	input  wire logic [pcsia_pkg::DW-1:0]      file_rdata_i
);

	// Architectural state.
	logic [pcsia_pkg::PC_W-1:0]    pc_reg;        // Full counter.
	logic [pcsia_pkg::PC_W-1:0]    pc_next;       // Its next value.
	logic [pcsia_pkg::HIGH_W-1:0]  latch_reg;     // High latch, five bits.
	logic [pcsia_pkg::DW-1:0]      fptr_reg;      // Indirect pointer.
	logic                          ibank_reg;     // Indirect bank bit.

	// Bus sequencer state.
	pcsia_pkg::pcsia_bus_state_t   state_reg;     // Current state.
	pcsia_pkg::pcsia_bus_state_t   state_next;    // Next state.
	logic                          ack_reg;       // Registered acknowledge.
	logic                          ack_next;      // Its next value.
	logic [pcsia_pkg::WB_DW-1:0]   dat_reg;       // Registered read data.
	logic [pcsia_pkg::WB_DW-1:0]   dat_next;      // Its next value.

	// File port registers.
	logic                          fstb_reg;      // File strobe.
	logic                          fwe_reg;       // File write enable.
	logic [pcsia_pkg::FILE_AW-1:0] faddr_reg;     // File address.
	logic [pcsia_pkg::DW-1:0]      fwdat_reg;     // File write data.

	// Bus decode.
	logic                          req;           // Cycle and strobe both high.
	logic [pcsia_pkg::IDX_W-1:0]   widx;          // Word index.
	logic                          hit_ind;       // Data port selected.
	logic                          hit_plow;      // Low byte selected.
	logic                          hit_bank;      // Bank register selected.
	logic                          hit_fptr;      // Pointer selected.
	logic                          hit_latch;     // High latch selected.
	logic                          idle_req;      // New request seen in idle.
	logic                          wr_lane;       // Write with low lane enabled.
	logic                          needs_file;    // Request goes to the file.
	logic                          dir_fire;      // Local access completes now.
	logic                          file_issue;    // File access starts now.
	logic                          plow_wr;       // Low byte write strobe.
	logic                          fptr_wr;       // Pointer write strobe.
	logic                          latch_wr;      // Latch write strobe.
	logic                          bank_wr;       // Bank register write strobe.
	logic [pcsia_pkg::DW-1:0]      wbyte;         // Written byte.
	logic [pcsia_pkg::DW-1:0]      rd_byte;       // Local read byte.

	// Sequencing decode.
	logic                          do_irq;        // Vector taken.
	logic                          do_call;       // Call taken.
	logic                          do_goto;       // Goto taken.
	logic                          do_ret;        // Return taken.
	logic                          do_push;       // Stack push.
	logic                          do_pop;        // Stack pop.
	logic [pcsia_pkg::PC_W-1:0]    push_val;      // Value pushed.
	logic [pcsia_pkg::PC_W-1:0]    jump_tgt;      // Call or goto target.
	logic [pcsia_pkg::PC_W-1:0]    stack_top;     // Newest stack entry.

	// Indirect address pieces.
	logic [pcsia_pkg::FILE_AW-1:0] ind_addr;      // Bank bit and pointer.
	logic                          ind_self;      // Pointer aims at the port.

	// Increment without any paging effect; used for push and advance.
	function automatic logic [pcsia_pkg::PC_W-1:0] pc_plus1(
		input logic [pcsia_pkg::PC_W-1:0] pc
	);
		pc_plus1 = pc + pcsia_pkg::PC_ONE;
	endfunction

	// The return stack; its pointer is invisible to software.
	pcsia_stack u_stack (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.push_i      (do_push),
		.pop_i       (do_pop),
		.push_data_i (push_val),
		.top_o       (stack_top)
	);

	// Indirect address former.
	pcsia_indaddr u_ind (
		.fptr_i (fptr_reg),
		.ibank_i(ibank_reg),
		.addr_o (ind_addr),
		.self_o (ind_self)
	);

	// Address decode on word index; only the low byte lane carries data.
	assign req       = wb_cyc_i & wb_stb_i;
	assign widx      = wb_adr_i[pcsia_pkg::WB_AW-1:2];
	assign hit_ind   = (widx == pcsia_pkg::IDX_INDIRECT);
	assign hit_plow  = (widx == pcsia_pkg::IDX_PC_LOW);
	assign hit_bank  = (widx == pcsia_pkg::IDX_BANK);
	assign hit_fptr  = (widx == pcsia_pkg::IDX_FPTR);
	assign hit_latch = (widx == pcsia_pkg::IDX_PCLATH);
	assign wbyte     = wb_dat_i[pcsia_pkg::DW-1:0];
	assign wr_lane   = wb_we_i & wb_sel_i[0];

	// The data port has no storage and forwards unless it aims at itself.
	assign idle_req   = req & (state_reg == pcsia_pkg::ST_IDLE);
	assign needs_file = hit_ind & ~ind_self;
	assign dir_fire   = idle_req & ~needs_file;
	assign file_issue = idle_req & needs_file;

	// Local write strobes; a self-write of the data port matches none.
	assign plow_wr  = dir_fire & wr_lane & hit_plow;
	assign fptr_wr  = dir_fire & wr_lane & hit_fptr;
	assign latch_wr = dir_fire & wr_lane & hit_latch;
	assign bank_wr  = dir_fire & wr_lane & hit_bank;

	// Local read data; upper counter bits have no read path at all.
	assign rd_byte = hit_plow  ? pc_reg[pcsia_pkg::LOW_W-1:0] :
		hit_fptr  ? fptr_reg :
		hit_latch ? {3'h0, latch_reg} :
		hit_bank  ? {ibank_reg, 7'h00} :
		pcsia_pkg::BYTE_ZERO;

	// Command priority: vector, call, goto, return, then bus write, advance.
	assign do_irq  = ce_i & core_irq_i;
	assign do_call = ce_i & core_call_i & ~core_irq_i;
	assign do_goto = ce_i & core_goto_i & ~core_irq_i & ~core_call_i;
	assign do_ret  = ce_i & core_ret_i & ~core_irq_i & ~core_call_i & ~core_goto_i;
	assign do_push = do_irq | do_call;
	assign do_pop  = do_ret;

	// A call pushes the following address; a vector pushes the address
	// that was about to run, since that instruction never executed.
	assign push_val = do_irq ? pc_reg : pc_plus1(pc_reg);

	// Only the two page bits come from the latch on a jump.
	assign jump_tgt = {latch_reg[pcsia_pkg::LATCH_PAGE_HI:pcsia_pkg::LATCH_PAGE_LO],
		core_lit_i};

	// Next counter value; a low byte write never carries, so tables that
	// cross a 256-word block must set the latch themselves.
	assign pc_next = do_irq ? pcsia_pkg::IRQ_VECTOR :
		(do_call | do_goto) ? jump_tgt :
		do_ret ? stack_top :
		plow_wr ? {latch_reg, wbyte} :
		core_inc_i ? pc_plus1(pc_reg) :
		pc_reg;

	// Program counter register; reset clears every bit, the upper included.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_reg <= pcsia_pkg::PC_RST;
		end else if (ce_i) begin
			pc_reg <= pc_next;
		end
	end

	// Software registers; stack traffic has no path into the latch.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_reg <= pcsia_pkg::LATCH_RST;
			fptr_reg  <= pcsia_pkg::FPTR_RST;
			ibank_reg <= 1'b0;
		end else if (ce_i) begin
			if (latch_wr) begin
				latch_reg <= wbyte[pcsia_pkg::HIGH_W-1:0];
			end
			if (fptr_wr) begin
				fptr_reg <= wbyte;
			end
			if (bank_wr) begin
				ibank_reg <= wbyte[pcsia_pkg::BANK_SEL_BIT];
			end
		end
	end

	// Sequencer: local accesses answer at once, file accesses one cycle
	// later, and every answer is followed by a cycle with ack low.
	always_comb begin
		state_next = state_reg;
		ack_next   = 1'b0;
		dat_next   = dat_reg;
		unique case (state_reg)
			pcsia_pkg::ST_IDLE: begin
				if (dir_fire) begin
					// Writes read back as zero; reads show the register.
					ack_next   = 1'b1;
					dat_next   = wb_we_i ? pcsia_pkg::WORD_ZERO : {24'h000000, rd_byte};
					state_next = pcsia_pkg::ST_ACK;
				end else if (file_issue) begin
					// Wait for the file to answer.
					state_next = pcsia_pkg::ST_FILE;
				end
			end
			pcsia_pkg::ST_FILE: begin
				// The file answers in the same cycle as its strobe.
				ack_next   = 1'b1;
				dat_next   = wb_we_i ? pcsia_pkg::WORD_ZERO : {24'h000000, file_rdata_i};
				state_next = pcsia_pkg::ST_ACK;
			end
			pcsia_pkg::ST_ACK: begin
				// Drop ack; the master releases its request here.
				state_next = pcsia_pkg::ST_IDLE;
			end
		endcase
	end

	// Bus sequencer registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= pcsia_pkg::ST_IDLE;
			ack_reg   <= 1'b0;
			dat_reg   <= pcsia_pkg::WORD_ZERO;
		end else if (ce_i) begin
			state_reg <= state_next;
			ack_reg   <= ack_next;
			dat_reg   <= dat_next;
		end
	end

	// File port: a one-cycle strobe carrying the formed address.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fstb_reg  <= 1'b0;
			fwe_reg   <= 1'b0;
			faddr_reg <= {pcsia_pkg::FILE_AW{1'b0}};
			fwdat_reg <= pcsia_pkg::BYTE_ZERO;
		end else if (ce_i) begin
			fstb_reg <= file_issue;
			if (file_issue) begin
				fwe_reg   <= wr_lane;
				faddr_reg <= ind_addr;
				fwdat_reg <= wbyte;
			end
		end
	end

	// Outputs straight from flip-flops; fetch ignores the page bits.
	assign pc_o         = pc_reg;
	assign fetch_addr_o = pc_reg[pcsia_pkg::FETCH_W-1:0];
	assign wb_ack_o     = ack_reg;
	assign wb_dat_o     = dat_reg;
	assign file_stb_o   = fstb_reg;
	assign file_we_o    = fwe_reg;
	assign file_addr_o  = faddr_reg;
	assign file_wdata_o = fwdat_reg;

	// Steps of a call followed directly by its return.
	sequence s_call;
		do_call;
	endsequence

	sequence s_ret;
		do_ret;
	endsequence

	chk_call_return: assert property (@(posedge clk_i) disable iff (rst_i)
		s_call ##1 s_ret |=> pc_reg == $past(pc_reg, 2) + pcsia_pkg::PC_ONE)
		else $error("return did not resume after the call");

	chk_irq_push: assert property (@(posedge clk_i) disable iff (rst_i)
		do_irq |=> stack_top == $past(pc_reg) && pc_reg == pcsia_pkg::IRQ_VECTOR)
		else $error("vector did not push the pending address");

	chk_plow_load: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && plow_wr && !do_irq && !do_call && !do_goto && !do_ret
		|=> pc_reg == {$past(latch_reg), $past(wbyte)})
		else $error("low byte write did not load the latch bits");

	chk_goto_page: assert property (@(posedge clk_i) disable iff (rst_i)
		do_goto |=> pc_reg[12:11] == $past(latch_reg[4:3])
			&& pc_reg[10:0] == $past(core_lit_i))
		else $error("goto target not formed from page bits");

	chk_reset_high: assert property (@(posedge clk_i)
		rst_i |=> pc_reg[12:8] == 5'h00)
		else $error("upper counter bits survived reset");

	chk_latch_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_push || do_pop) && !latch_wr |=> $stable(latch_reg))
		else $error("stack operation altered the latch");

	chk_self_read: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && dir_fire && hit_ind && !wb_we_i |=> wb_ack_o && wb_dat_o == 32'h00000000)
		else $error("self read through data port not zero");

	chk_self_write: assert property (@(posedge clk_i) disable iff (rst_i)
		dir_fire && hit_ind |=> !file_stb_o && $stable(fptr_reg) && $stable(latch_reg))
		else $error("self write through data port stored data");

	chk_file_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		file_issue && ce_i |=> file_stb_o && file_addr_o == $past({ibank_reg, fptr_reg})
			##1 wb_ack_o)
		else $error("indirect access address or answer wrong");

	chk_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

// ===== include/pcsia_pkg.sv
package pcsia_pkg;

	// Program counter and stack geometry.
	localparam int PC_W    = 13;
	localparam int LOW_W   = 8;
	localparam int HIGH_W  = 5;
	localparam int LIT_W   = 11;
	localparam int FETCH_W = 11;
	localparam int DEPTH   = 8;
	localparam int PTR_W   = 3;

	// Indirect addressing and register bus widths.
	localparam int FILE_AW = 9;
	localparam int DW      = 8;
	localparam int WB_DW   = 32;
	localparam int WB_AW   = 6;
	localparam int IDX_W   = 4;
	localparam int SEL_W   = 4;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_INDIRECT = 4'h0;
	localparam logic [IDX_W-1:0] IDX_PC_LOW   = 4'h2;
	localparam logic [IDX_W-1:0] IDX_BANK     = 4'h3;
	localparam logic [IDX_W-1:0] IDX_FPTR     = 4'h4;
	localparam logic [IDX_W-1:0] IDX_PCLATH   = 4'hA;

	// Field positions.
	localparam int BANK_SEL_BIT  = 7;
	localparam int LATCH_PAGE_HI = 4;
	localparam int LATCH_PAGE_LO = 3;

	// Reset values and fixed codes.
	localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
	localparam logic [HIGH_W-1:0] LATCH_RST  = 5'h00;
	localparam logic [DW-1:0]     FPTR_RST   = 8'h00;
	localparam logic [DW-1:0]     FPTR_SELF  = 8'h00;
	localparam logic [DW-1:0]     BYTE_ZERO  = 8'h00;
	localparam logic [WB_DW-1:0]  WORD_ZERO  = 32'h00000000;
	localparam logic [PTR_W-1:0]  PTR_RST    = 3'h0;
	localparam logic [PTR_W-1:0]  PTR_ONE    = 3'h1;
	localparam logic [PC_W-1:0]   PC_ONE     = 13'h0001;
	localparam logic [PC_W-1:0]   IRQ_VECTOR = 13'h0004;

	// Register bus sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FILE,
		ST_ACK
	} pcsia_bus_state_t;

endpackage

// ===== src/pcsia_indaddr.sv
`timescale 1ns/1ps
module pcsia_indaddr (
	// Pointer state.
	input  wire logic [pcsia_pkg::DW-1:0]      fptr_i,
	input  wire logic                          ibank_i,
	// Formed address.
	output logic      [pcsia_pkg::FILE_AW-1:0] addr_o,
	output logic                               self_o
);

	// The bank bit sits above the pointer to give the full file address.
	assign addr_o = {ibank_i, fptr_i};

	// A zero pointer makes the data port point at itself.
	assign self_o = (fptr_i == pcsia_pkg::FPTR_SELF);

endmodule

// ===== src/pcsia_stack.sv
`timescale 1ns/1ps
module pcsia_stack (
	// Clock, reset and enable.
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	// Stack operations.
	input  wire logic                       push_i,
	input  wire logic                       pop_i,
	input  wire logic [pcsia_pkg::PC_W-1:0] push_data_i,
	output logic      [pcsia_pkg::PC_W-1:0] top_o
);

	// Entries are never cleared; only the pointer has a reset value.
	logic [pcsia_pkg::PC_W-1:0]  mem [pcsia_pkg::DEPTH];
	logic [pcsia_pkg::PTR_W-1:0] ptr_reg;

	// The pointer wraps in both directions, with no flag for it.
	function automatic logic [pcsia_pkg::PTR_W-1:0] ptr_step(
		input logic [pcsia_pkg::PTR_W-1:0] p,
		input logic                        up
	);
		if (up) begin
			ptr_step = p + pcsia_pkg::PTR_ONE;
		end else begin
			ptr_step = p - pcsia_pkg::PTR_ONE;
		end
	endfunction

	// The newest entry lies just below the pointer.
	assign top_o = mem[ptr_step(ptr_reg, 1'b0)];

	// Pointer update; a pop on an empty stack simply wraps.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_reg <= pcsia_pkg::PTR_RST;
		end else if (ce_i && push_i) begin
			ptr_reg <= ptr_step(ptr_reg, 1'b1);
		end else if (ce_i && pop_i) begin
			ptr_reg <= ptr_step(ptr_reg, 1'b0);
		end
	end

	// The ninth push lands on the slot of the first.
	always_ff @(posedge clk_i) begin
		if (!rst_i && ce_i && push_i) begin
			mem[ptr_reg] <= push_data_i;
		end
	end

	// Eight pushes bring the pointer back to where it started.
	chk_wrap_eight: assert property (@(posedge clk_i) disable iff (rst_i)
		(push_i && ce_i)[*8] |=> ptr_reg == $past(ptr_reg, 8))
		else $error("stack pointer did not wrap after eight pushes");

endmodule

// ===== test/pcsia_file_model.sv
`timescale 1ns/1ps
// Register file behind the indirect port; it answers while the read strobe stands.
module pcsia_file_model (
	// Clock.
	input  wire logic                          clk_i,
	// Access from the block.
	input  wire logic                          file_stb_i,
	input  wire logic                          file_we_i,
	input  wire logic [pcsia_pkg::FILE_AW-1:0] file_addr_i,
	input  wire logic [pcsia_pkg::DW-1:0]      file_wdata_i,
	output logic      [pcsia_pkg::DW-1:0]      file_rdata_o
);
	logic [pcsia_pkg::DW-1:0] mem [512]; // Storage addressed by bank bit and pointer.
	logic [pcsia_pkg::DW-1:0] junk;      // Changes every cycle so stale data never matches.

	initial junk = 8'hA5;

	// Writes land on the edge that sees the strobe; the idle pattern keeps moving.
	always @(posedge clk_i) begin
		junk <= ~junk ^ 8'h3C;
		if (file_stb_i && file_we_i) begin
			mem[file_addr_i] <= file_wdata_i;
		end
	end

	// Read data is valid only during a read strobe, as a real file would behave.
	assign file_rdata_o = (file_stb_i && !file_we_i) ? mem[file_addr_i] : junk;
endmodule

// ===== test/pc_stack_indirect_addressing_bench.sv
`timescale 1ns/1ps
module pc_stack_indirect_addressing_bench;
	logic        clk_i = 1'b0;                       // Core clock.
	logic        rst_i = 1'b1, ce_i = 1'b1;         // Reset and run enable.
	logic        inc, gto, cal, ret, irq;            // Core commands.
	logic [10:0] lit;                                // Jump literal.
	logic [12:0] pc_o;                               // Program counter view.
	logic [10:0] fetch_o;                            // Fetch address view.
	logic        cyc, stb, we, ack, fstb, fwe;       // Bus and file strobes.
	logic [5:0]  adr;                                // Bus byte address.
	logic [3:0]  sel;                                // Byte lanes.
	logic        bsel = 1'b1;                        // Low lane enable for the next request.
	logic [31:0] dati, dato, rd;                     // Bus data.
	logic [8:0]  faddr, last_addr;                   // File address.
	logic [7:0]  fwd, frd;                           // File data.
	int          failures = 0, comparisons = 0;      // Report counters.
	int          m_pc, m_lat, m_sp, stb_cnt;         // Reference state.
	int          m_stk [8];                          // Reference return stack.
	int          fmem [int];                         // Bytes written through the port.
	int          a, b, n;                            // Scratch.

	always #5 clk_i = ~clk_i;

	pcsia_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .core_inc_i(inc),
		.core_goto_i(gto), .core_call_i(cal), .core_ret_i(ret), .core_irq_i(irq),
		.core_lit_i(lit), .pc_o(pc_o), .fetch_addr_o(fetch_o), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati),
		.wb_dat_o(dato), .wb_ack_o(ack), .file_stb_o(fstb), .file_we_o(fwe),
		.file_addr_o(faddr), .file_wdata_o(fwd), .file_rdata_i(frd));

	pcsia_file_model FILE (.clk_i(clk_i), .file_stb_i(fstb), .file_we_i(fwe),
		.file_addr_i(faddr), .file_wdata_i(fwd), .file_rdata_o(frd));

	// Count file strobes so a self-addressed write can be shown to reach nothing.
	always @(posedge clk_i) begin
		if (fstb === 1'b1) begin
			stb_cnt++;
			last_addr = faddr;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One classic cycle; the request stands until ack is sampled, then drops.
	task automatic bus(input logic w, input logic [5:0] ad, input int d);
		int k;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= ad;
		sel  <= {3'($urandom), bsel};
		dati <= {24'($urandom), 8'(d)};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		// Read data is taken at the very edge that shows ack; a lost answer ends the run.
		if (ack === 1'b1) begin
			rd = dato;
			cyc <= 1'b0;
			stb <= 1'b0;
		end else begin
			failures++;
			$display("BAD %0t bus answer missing", $time);
			finish_test();
		end
	endtask

	// One core command for one edge, then the model steps and the views are compared.
	task automatic core(input int kind, input int l);
		int tgt;
		tgt = (((m_lat >> 3) & 3) << 11) | (l & 'h7FF);
		@(posedge clk_i);
		{irq, cal, ret, gto, inc} <= 5'(1 << kind);
		lit <= 11'(l);
		@(posedge clk_i);
		{irq, cal, gto, ret, inc} <= 5'h00;
		#1;
		case (kind)
			0: m_pc = (m_pc + 1) % 8192;
			1: m_pc = tgt;
			3: begin
				m_stk[m_sp] = (m_pc + 1) % 8192;
				m_sp = (m_sp + 1) % 8;
				m_pc = tgt;
			end
			2: begin
				m_sp = (m_sp + 7) % 8;
				m_pc = m_stk[m_sp];
			end
			default: begin
				m_stk[m_sp] = m_pc;
				m_sp = (m_sp + 1) % 8;
				m_pc = 4;
			end
		endcase
		chk(pc_o, m_pc, "program counter");
		chk(fetch_o, m_pc & 'h7FF, "fetch address");
	endtask

	// Main sequence; bit numbers of kind: 0 inc, 1 goto, 2 return, 3 call, 4 interrupt.
	initial begin
		{inc, gto, cal, ret, irq, cyc, stb, we} = 8'h00;
		{lit, adr, dati, sel} = '0;
		sel = 4'h1;
		{m_pc, m_lat, m_sp, stb_cnt} = '0;
		void'($urandom(32'heedd));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 6'h08, 0);
		chk(rd, 0, "low byte after reset");
		chk(pc_o, 0, "counter after reset");
		// Latch then low byte: the whole upper part follows the latch.
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			b = $urandom;
			bus(1'b1, 6'h28, a);
			m_lat = a & 'h1F;
			bus(1'b1, 6'h08, b);
			m_pc = (m_lat << 8) | (b & 'hFF);
			#1 chk(pc_o, m_pc, "counter after low write");
			bus(1'b0, 6'h28, 0);
			chk(rd, m_lat, "latch read");
			bus(1'b0, 6'h08, 0);
			chk(rd, m_pc & 'hFF, "low byte read");
		end
		// Ten calls and an interrupt wrap the stack; twelve returns over-pop it.
		bus(1'b1, 6'h28, 'h18);
		m_lat = 'h18;
		for (int i = 0; i < 10; i++) core(3, $urandom);
		core(4, 0);
		// Eight calls on consecutive edges wrap the pointer; a return follows at once.
		a = $urandom;
		@(posedge clk_i);
		cal <= 1'b1;
		lit <= 11'(a);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			m_stk[m_sp] = (m_pc + 1) % 8192;
			m_sp = (m_sp + 1) % 8;
			m_pc = (((m_lat >> 3) & 3) << 11) | (a & 'h7FF);
		end
		cal <= 1'b0;
		ret <= 1'b1;
		@(posedge clk_i);
		ret <= 1'b0;
		m_sp = (m_sp + 7) % 8;
		m_pc = m_stk[m_sp];
		#1 chk(pc_o, m_pc, "call then return");
		for (int i = 0; i < 12; i++) core(2, 0);
		bus(1'b0, 6'h28, 0);
		chk(rd, m_lat, "latch after stack use");
		// A write with the low lane off must leave the latch alone.
		bsel = 1'b0;
		bus(1'b1, 6'h28, 'h07);
		bsel = 1'b1;
		bus(1'b0, 6'h28, 0);
		chk(rd, m_lat, "latch after lane-off write");
		for (int i = 0; i < 3; i++) core(0, 0);
		// With the enable low the counter holds although an advance is asked for.
		@(posedge clk_i);
		ce_i <= 1'b0;
		inc  <= 1'b1;
		repeat (3) @(posedge clk_i);
		ce_i <= 1'b1;
		inc  <= 1'b0;
		#1 chk(pc_o, m_pc, "counter frozen by enable");
		core(1, $urandom);
		// Indirect writes and read-back through the pointer; bank bit stays clear.
		bus(1'b1, 6'h0C, 0);
		bus(1'b0, 6'h0C, 0);
		chk(rd, 0, "bank register read");
		for (int i = 0; i < 4; i++) begin
			a = 1 + $urandom_range(254);
			b = $urandom_range(255);
			bus(1'b1, 6'h10, a);
			bus(1'b1, 6'h00, b);
			fmem[a] = b;
			chk(last_addr, a, "file address");
		end
		foreach (fmem[k]) begin
			bus(1'b1, 6'h10, k);
			bus(1'b0, 6'h00, 0);
			chk(rd, fmem[k], "indirect read");
		end
		// Pointer zero: the port reads as zero and a write goes nowhere.
		bus(1'b1, 6'h10, 0);
		n = stb_cnt;
		bus(1'b1, 6'h00, 'h77);
		bus(1'b0, 6'h00, 0);
		chk(rd, 0, "self read");
		chk(stb_cnt, n, "self write strobes");
		bus(1'b0, 6'h3C, 0);
		chk(rd, 0, "unmapped read");
		// Reset in mid-run clears the upper counter bits again.
		core(1, 'h7FF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk(pc_o, 0, "counter after second reset");
		bus(1'b0, 6'h08, 0);
		chk(rd, 0, "low byte after second reset");
		finish_test();
	end
endmodule
